// [hw/psbs_defs.vh]
// Constants shared by the pipelined burst SRAM core.
// Assumes inclusion by bare name from the core file.
`ifndef PSBS_DEFS_VH
`define PSBS_DEFS_VH

`define PSBS_ADDR_W      17
`define PSBS_HI_W        15
`define PSBS_DATA_W      32
`define PSBS_LANES       4
`define PSBS_WORDS       131072
`define PSBS_FIFO_DEPTH  16
`define PSBS_FIFO_AW     4
`define PSBS_FIFO_W      53
`define PSBS_STEP_RST    2'h0
`define PSBS_STEP_ONE    2'h1
`define PSBS_STEP_LAST   2'h3
`define PSBS_STROBE_RST  1'h1

`endif

// [hw/psbs_sram.v]
// Pipelined burst synchronous SRAM core, 128K words of 32 bits, plus its write buffer.
// Assumes a master on core_clk driving the bus; sleep and drive enable are asynchronous.
//
// Summary of operation
// - Address, data, selects, writes and burst controls sampled on rising clock.
// - Array holds 128K words of 32 bits on a 17-bit word address.
// - A 2-bit burst counter covers up to four words from the base.
// - Controller strobe low loads the address and the two low bits into counter.
// - With both strobes low and first select low, only the processor strobe is obeyed.
// - Processor strobe is ignored while the first select is high.
// - Burst address advances in each burst cycle the advance input is high, except the write cycle right after a processor strobe.
// - Global write low writes all 32 bits of the word.
// - Byte write function enable writes only the selected byte lanes.
// - Selected only when first and third selects low and second high.
// - Drive enable gates the data drivers without a clock.
// - Asynchronous sleep input enters low power, keeping array contents.
// - Read data passes an output register, one clock after its address.
// - Static order select picks interleaved or linear burst sequence.
// - Array writes are timed internally from the clock edge.
// - Processor-strobe access takes two cycles; deselect takes one.
// - Global write overrides byte write enable and lane selects.
// - Processor-strobe write ignores write controls in first cycle; write on second.
// - Controller-strobe write with processor strobe high completes in one cycle.

`include "psbs_defs.vh"

`default_nettype none

module psbs_write_fifo #(
    parameter WIDTH = `PSBS_FIFO_W,
    parameter DEPTH = `PSBS_FIFO_DEPTH,
    parameter AW    = `PSBS_FIFO_AW
) (
    input  wire             core_clk,   // Core clock
    input  wire             srst,       // Synchronous reset
    input  wire             in_valid,   // Entry offered
    output wire             in_ready,   // Room for an entry
    input  wire [WIDTH-1:0] in_data,    // Entry offered
    output wire             out_valid,  // Entry waiting
    input  wire             out_ready,  // Consumer takes entry
    output wire [WIDTH-1:0] out_data    // Oldest entry
);

    reg  [WIDTH-1:0] store_r [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_r;
    reg  [AW-1:0]    rd_ptr_r;
    reg  [AW:0]      count_r;
    wire             push;
    wire             pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = store_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge core_clk)
    begin
        if (push)
            store_r[wr_ptr_r] <= in_data;
    end

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            if (push & ~pop)
                count_r <= count_r + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                count_r <= count_r - {{AW{1'b0}}, 1'b1};
        end
    end

endmodule

module psbs_sram (
    input  wire                  core_clk,                     // 200 MHz clock
    input  wire                  srst,                         // Synchronous reset
    input  wire [`PSBS_HI_W-1:0] address_high,                 // Upper word address
    input  wire [1:0]            burst_low_address,            // Low address, burst base
    input  wire                  chip_select_first_n,          // Select, active low
    input  wire                  chip_select_second,           // Select, active high
    input  wire                  chip_select_third_n,          // Select, active low
    input  wire                  processor_address_strobe_n,   // Processor strobe
    input  wire                  controller_address_strobe_n,  // Controller strobe
    input  wire                  burst_advance,                // Advance burst
    input  wire                  global_write_n,               // Write all lanes
    input  wire                  byte_write_function_en_n,     // Enable lane writes
    input  wire                  byte_lane0_select_n,          // Lane 0 write
    input  wire                  byte_lane1_select_n,          // Lane 1 write
    input  wire                  byte_lane2_select_n,          // Lane 2 write
    input  wire                  byte_lane3_select_n,          // Lane 3 write
    input  wire                  output_drive_en_n,            // Asynchronous drive enable
    input  wire                  burst_order_linear,           // 1 linear, 0 interleaved
    input  wire                  sleep_request,                // Asynchronous sleep
    input  wire [7:0]            data_lane0_in,                // Lane 0 pin level
    input  wire [7:0]            data_lane1_in,                // Lane 1 pin level
    input  wire [7:0]            data_lane2_in,                // Lane 2 pin level
    input  wire [7:0]            data_lane3_in,                // Lane 3 pin level
    output wire [7:0]            data_lane0_out,               // Lane 0 read data
    output wire [7:0]            data_lane1_out,               // Lane 1 read data
    output wire [7:0]            data_lane2_out,               // Lane 2 read data
    output wire [7:0]            data_lane3_out,               // Lane 3 read data
    output wire                  data_lanes_oe,                // Drive all lanes
    output wire                  write_buffer_ready,           // Write buffer has room
    output wire                  sleeping                      // In low power state
);

    // Lane mask of a write; global write wins over lane selects
    function [`PSBS_LANES-1:0] write_lanes;
        input                    gw_n;
        input                    bwe_n;
        input [`PSBS_LANES-1:0]  sel_n;
        begin
            if (!gw_n)
                write_lanes = {`PSBS_LANES{1'b1}};
            else if (!bwe_n)
                write_lanes = ~sel_n;
            else
                write_lanes = {`PSBS_LANES{1'b0}};
        end
    endfunction

    // Low address bits for a burst step
    function [1:0] burst_low;
        input [1:0] base;
        input [1:0] step;
        input       linear;
        begin
            if (linear)
                burst_low = base + step;
            else
                burst_low = base ^ step;
        end
    endfunction

    // Input register stage
    reg  [`PSBS_HI_W-1:0]  in_hi_r;
    reg  [1:0]             in_low_r;
    reg                    in_cs1_n_r;
    reg                    in_cs2_r;
    reg                    in_cs3_n_r;
    reg                    in_processor_address_strobe_n_n_r;
    reg                    in_controller_address_strobe_n_n_r;
    reg                    in_adv_r;
    reg                    in_gw_n_r;
    reg                    in_bwe_n_r;
    reg  [`PSBS_LANES-1:0] in_bsel_n_r;
    reg  [`PSBS_DATA_W-1:0] in_data_r;

    // Burst state
    reg  [`PSBS_HI_W-1:0]  hi_r;
    reg  [1:0]             base_r;
    reg  [1:0]             step_r;
    reg                    active_r;
    reg                    first_r;
    reg                    sleep_meta_r;
    reg                    asleep_r;
    reg                    buf_ready_r;

    // Array and output register
    reg  [`PSBS_DATA_W-1:0] mem_r [0:`PSBS_WORDS-1];
    reg  [`PSBS_DATA_W-1:0] dout_r;
    reg                     rd_valid_r;

    reg                     selected;
    reg                     processor_address_strobe_n_take;
    reg                     load;
    reg  [1:0]              step_nxt;
    reg                     active_nxt;
    reg                     first_nxt;
    reg                     acc_rd;
    reg                     acc_wr;
    reg  [`PSBS_LANES-1:0]  acc_be;
    reg  [`PSBS_HI_W-1:0]   hi_nxt;
    reg  [1:0]              base_nxt;
    reg  [`PSBS_ADDR_W-1:0] acc_addr;

    wire [`PSBS_LANES-1:0]  wbe;
    wire                    fifo_in_ready;
    wire                    fifo_out_valid;
    wire [`PSBS_FIFO_W-1:0] fifo_out_data;
    wire [`PSBS_ADDR_W-1:0] drain_addr;
    wire [`PSBS_LANES-1:0]  drain_be;
    wire [`PSBS_DATA_W-1:0] drain_data;
    wire                    drain_go;
    integer                 i;

    // Address, controls and data sampled on the rising edge
    always @(posedge core_clk)
    begin
        in_hi_r    <= address_high;
        in_low_r   <= burst_low_address;
        in_adv_r   <= burst_advance;
        in_data_r  <= {data_lane3_in, data_lane2_in, data_lane1_in, data_lane0_in};
        if (srst)
        begin
            in_cs1_n_r  <= `PSBS_STROBE_RST;
            in_cs2_r    <= 1'b0;
            in_cs3_n_r  <= `PSBS_STROBE_RST;
            in_processor_address_strobe_n_n_r <= `PSBS_STROBE_RST;
            in_controller_address_strobe_n_n_r <= `PSBS_STROBE_RST;
            in_gw_n_r   <= `PSBS_STROBE_RST;
            in_bwe_n_r  <= `PSBS_STROBE_RST;
            in_bsel_n_r <= {`PSBS_LANES{1'b1}};
        end
        else
        begin
            in_cs1_n_r  <= chip_select_first_n;
            in_cs2_r    <= chip_select_second;
            in_cs3_n_r  <= chip_select_third_n;
            in_processor_address_strobe_n_n_r <= processor_address_strobe_n;
            in_controller_address_strobe_n_n_r <= controller_address_strobe_n;
            in_gw_n_r   <= global_write_n;
            in_bwe_n_r  <= byte_write_function_en_n;
            in_bsel_n_r <= {byte_lane3_select_n, byte_lane2_select_n,
                            byte_lane1_select_n, byte_lane0_select_n};
        end
    end

    assign wbe = write_lanes(in_gw_n_r, in_bwe_n_r, in_bsel_n_r);

    // Access decode
    always @*
    begin
        selected   = ~in_cs1_n_r & in_cs2_r & ~in_cs3_n_r;
        processor_address_strobe_n_take  = ~in_processor_address_strobe_n_n_r & ~in_cs1_n_r;
        load       = 1'b0;
        step_nxt   = step_r;
        active_nxt = active_r;
        first_nxt  = 1'b0;
        acc_rd     = 1'b0;
        acc_wr     = 1'b0;
        acc_be     = {`PSBS_LANES{1'b0}};
        if (!asleep_r)
        begin
            if (processor_address_strobe_n_take)
            begin
                active_nxt = selected;
                if (selected)
                begin
                    load      = 1'b1;
                    first_nxt = 1'b1;
                    acc_rd    = 1'b1;
                end
            end
            else if (!in_controller_address_strobe_n_n_r)
            begin
                active_nxt = selected;
                if (selected)
                begin
                    load   = 1'b1;
                    acc_wr = |wbe;
                    acc_rd = ~|wbe;
                    acc_be = wbe;
                end
            end
            else if (active_r)
            begin
                if (in_adv_r & ~(first_r & |wbe))
                    step_nxt = step_r + `PSBS_STEP_ONE;
                else
                    step_nxt = step_r;
                acc_wr = |wbe;
                acc_rd = ~|wbe;
                acc_be = wbe;
            end
        end
        hi_nxt   = hi_r;
        base_nxt = base_r;
        if (load)
        begin
            hi_nxt   = in_hi_r;
            base_nxt = in_low_r;
            step_nxt = `PSBS_STEP_RST;
        end
        acc_addr = {hi_nxt, burst_low(base_nxt, step_nxt, burst_order_linear)};
    end

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            hi_r         <= {`PSBS_HI_W{1'b0}};
            base_r       <= 2'h0;
            step_r       <= `PSBS_STEP_RST;
            active_r     <= 1'b0;
            first_r      <= 1'b0;
            sleep_meta_r <= 1'b0;
            asleep_r     <= 1'b0;
            rd_valid_r   <= 1'b0;
            buf_ready_r  <= 1'b0;
        end
        else
        begin
            hi_r         <= hi_nxt;
            base_r       <= base_nxt;
            step_r       <= step_nxt;
            active_r     <= active_nxt;
            first_r      <= first_nxt;
            sleep_meta_r <= sleep_request;
            asleep_r     <= sleep_meta_r;
            rd_valid_r   <= acc_rd;
            buf_ready_r  <= fifo_in_ready;
        end
    end

    // Output register: data belongs to the address of the previous clock
    always @(posedge core_clk)
    begin
        if (acc_rd)
            dout_r <= mem_r[acc_addr];
    end

    // Writes are queued and drained into the array while awake
    psbs_write_fifo #(
        .WIDTH (`PSBS_FIFO_W),
        .DEPTH (`PSBS_FIFO_DEPTH),
        .AW    (`PSBS_FIFO_AW)
    ) u_wbuf (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (acc_wr),
        .in_ready  (fifo_in_ready),
        .in_data   ({acc_addr, acc_be, in_data_r}),
        .out_valid (fifo_out_valid),
        .out_ready (~asleep_r),
        .out_data  (fifo_out_data)
    );

    assign drain_addr = fifo_out_data[`PSBS_FIFO_W-1:`PSBS_FIFO_W-`PSBS_ADDR_W];
    assign drain_be   = fifo_out_data[`PSBS_DATA_W+`PSBS_LANES-1:`PSBS_DATA_W];
    assign drain_data = fifo_out_data[`PSBS_DATA_W-1:0];
    assign drain_go   = fifo_out_valid & ~asleep_r;

    // Self-timed array write, one word per clock, lanes by mask
    always @(posedge core_clk)
    begin
        if (drain_go)
            for (i = 0; i < `PSBS_LANES; i = i + 1)
                if (drain_be[i])
                    mem_r[drain_addr][8*i +: 8] <= drain_data[8*i +: 8];
    end

    assign data_lane0_out     = dout_r[7:0];
    assign data_lane1_out     = dout_r[15:8];
    assign data_lane2_out     = dout_r[23:16];
    assign data_lane3_out     = dout_r[31:24];
    assign data_lanes_oe      = rd_valid_r & ~output_drive_en_n;
    assign write_buffer_ready = buf_ready_r;
    assign sleeping           = asleep_r;

endmodule

`default_nettype wire

// [verification/psbs_master_pins.sv]
// Master side of the shared data lanes: resolves the level on all 32 lines.
// Assumes the bench raises drive_en only in write data cycles.
`default_nettype none
module psbs_master_pins (
    input  wire logic        core_clk,    // Clock
    input  wire logic [31:0] sram_data,   // Core read data
    input  wire logic        sram_oe,     // Core drives lanes
    input  wire logic        drive_en,    // Master drives lanes
    input  wire logic [31:0] drive_data,  // Master write data
    output logic      [31:0] lanes        // Wire level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] last_r = 32'h0;
    // Floating lanes show the inverse of the last level, never a kept value
    assign lanes = sram_oe ? sram_data : (drive_en ? drive_data : ~last_r);
    always @(posedge core_clk) last_r <= lanes;
endmodule
`default_nettype wire

// [verification/psbs_sram_sva.sv]
// Port-level assertions for the pipelined burst SRAM core.
// Assumes one clock domain; bound to the core by the bind below.
`default_nettype none
module psbs_sram_chk (
    input wire logic core_clk,                     // Clock
    input wire logic srst,                         // Synchronous reset
    input wire logic chip_select_first_n,          // Select, active low
    input wire logic chip_select_second,           // Select, active high
    input wire logic chip_select_third_n,          // Select, active low
    input wire logic processor_address_strobe_n,   // Processor strobe
    input wire logic controller_address_strobe_n,  // Controller strobe
    input wire logic global_write_n,               // Write all lanes
    input wire logic byte_write_function_en_n,     // Enable lane writes
    input wire logic output_drive_en_n,            // Drive enable
    input wire logic sleep_request,                // Sleep input
    input wire logic data_lanes_oe,                // Core drives lanes
    input wire logic sleeping                      // Low power state
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    wire c_go = !controller_address_strobe_n && processor_address_strobe_n;
    wire no_wr = global_write_n && byte_write_function_en_n;
    wire p_go = !processor_address_strobe_n && sel && !sleeping;

    read_oe_a: assert property (c_go && sel && no_wr ##1 !sleeping
        ##1 !output_drive_en_n |-> data_lanes_oe) else $error("read not driven");
    proc_read_a: assert property (!processor_address_strobe_n && sel ##1 !sleeping
        ##1 !output_drive_en_n |-> data_lanes_oe) else $error("processor read not driven");
    oe_async_a: assert property (output_drive_en_n |-> !data_lanes_oe)
        else $error("lanes driven while disabled");
    deselect_a: assert property (c_go && !sel |-> ##2 !data_lanes_oe)
        else $error("lanes driven after deselect");
    write_quiet_a: assert property (c_go && sel && !global_write_n |-> ##2 !data_lanes_oe)
        else $error("lanes driven after write");
    sleep_enter_a: assert property ($rose(sleep_request) |-> ##[1:4] sleeping)
        else $error("sleep not entered");
    sleep_quiet_a: assert property (sleeping ##1 sleeping |-> !data_lanes_oe)
        else $error("access while asleep");
    wake_up_a: assert property ($fell(sleep_request) |-> ##[1:4] !sleeping)
        else $error("sleep not left");

    cover property (c_go && sel && !global_write_n);
    cover property (p_go);
    cover property (sleeping ##1 sleeping);
endmodule

bind psbs_sram psbs_sram_chk chk (
    .core_clk(core_clk), .srst(srst), .chip_select_first_n(chip_select_first_n),
    .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
    .processor_address_strobe_n(processor_address_strobe_n),
    .controller_address_strobe_n(controller_address_strobe_n),
    .global_write_n(global_write_n), .byte_write_function_en_n(byte_write_function_en_n),
    .output_drive_en_n(output_drive_en_n), .sleep_request(sleep_request),
    .data_lanes_oe(data_lanes_oe), .sleeping(sleeping)
);
`default_nettype wire

// [verification/tb_psbs_sram.sv]
// Self-checking bench for the pipelined burst SRAM core.
// Assumes the master pin model resolves the shared data lanes.
`default_nettype none
module tb_psbs_sram;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [16:0] addr = 17'h0;
    logic        chip_select_first_n = 1'b0;
    logic        chip_select_second = 1'b1;
    logic        chip_select_third_n = 1'b0;
    logic        processor_address_strobe_n = 1'b1;
    logic        controller_address_strobe_n = 1'b1;
    logic        burst_advance = 1'b0;
    logic        global_write_n = 1'b1;
    logic        byte_write_function_en_n = 1'b1;
    logic [3:0]  sel_n = 4'hf;
    logic        output_drive_en_n = 1'b0;
    logic        burst_order_linear = 1'b1;
    logic        sleep_request = 1'b0;
    logic        drive_en = 1'b0;
    logic [31:0] drive_data = 32'h0;
    wire  [31:0] dout;
    wire  [31:0] lanes;
    wire         data_lanes_oe;
    wire         write_buffer_ready;
    wire         sleeping;
    int          fails = 0;
    int          compares = 0;

    always #2.5 core_clk = ~core_clk;

    psbs_master_pins partner (.core_clk(core_clk), .sram_data(dout), .sram_oe(data_lanes_oe),
        .drive_en(drive_en), .drive_data(drive_data), .lanes(lanes));

    psbs_sram dut (
        .core_clk(core_clk), .srst(srst), .address_high(addr[16:2]),
        .burst_low_address(addr[1:0]), .chip_select_first_n(chip_select_first_n),
        .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
        .processor_address_strobe_n(processor_address_strobe_n),
        .controller_address_strobe_n(controller_address_strobe_n),
        .burst_advance(burst_advance), .global_write_n(global_write_n),
        .byte_write_function_en_n(byte_write_function_en_n),
        .byte_lane0_select_n(sel_n[0]), .byte_lane1_select_n(sel_n[1]),
        .byte_lane2_select_n(sel_n[2]), .byte_lane3_select_n(sel_n[3]),
        .output_drive_en_n(output_drive_en_n), .burst_order_linear(burst_order_linear),
        .sleep_request(sleep_request), .data_lane0_in(lanes[7:0]),
        .data_lane1_in(lanes[15:8]), .data_lane2_in(lanes[23:16]),
        .data_lane3_in(lanes[31:24]), .data_lane0_out(dout[7:0]),
        .data_lane1_out(dout[15:8]), .data_lane2_out(dout[23:16]),
        .data_lane3_out(dout[31:24]), .data_lanes_oe(data_lanes_oe),
        .write_buffer_ready(write_buffer_ready), .sleeping(sleeping)
    );

    task automatic results;
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(negedge core_clk);
    endtask

    task automatic idle;
        processor_address_strobe_n = 1'b1;
        controller_address_strobe_n = 1'b1;
        burst_advance = 1'b0;
        {global_write_n, byte_write_function_en_n} = 2'b11;
        sel_n = 4'hf;
        drive_en = 1'b0;
    endtask

    task automatic settle;
        idle();
        output_drive_en_n = 1'b0;
        repeat (3) tick();
    endtask

    // Lanes are released by the drive enable so write data never collides
    task automatic wr(input logic [16:0] a, input logic [1:0] w_n, input logic [3:0] s_n,
                      input logic [31:0] d);
        output_drive_en_n = 1'b1;
        controller_address_strobe_n = 1'b0;
        addr = a;
        {global_write_n, byte_write_function_en_n} = w_n;
        sel_n = s_n;
        drive_en = 1'b1;
        drive_data = d;
        tick();
    endtask

    task automatic rd(input logic [16:0] a, input logic [31:0] exp);
        controller_address_strobe_n = 1'b0;
        addr = a;
        tick();
        idle();
        tick();
        chk(exp, dout);
        chk(32'h1, {31'h0, data_lanes_oe});
    endtask

    task automatic wait_sleep(input logic lvl);
        int n;
        for (n = 0; n < 10 && sleeping !== lvl; n++)
            tick();
        if (sleeping !== lvl)
        begin
            fails++;
            results();
        end
    endtask

    task automatic t_writes;
        wr(17'h1ffff, 2'b01, 4'hf, 32'hdeadbeef);
        settle();
        rd(17'h1ffff, 32'hdeadbeef);
        wr(17'h1ffff, 2'b10, 4'h5, 32'h11223344);
        settle();
        rd(17'h1ffff, 32'h11ad33ef);
        wr(17'h1ffff, 2'b00, 4'hf, 32'h55aa55aa);
        settle();
        rd(17'h1ffff, 32'h55aa55aa);
    endtask

    task automatic t_proc_write;
        wr(17'h00010, 2'b01, 4'hf, 32'h12345678);
        settle();
        output_drive_en_n = 1'b1;
        processor_address_strobe_n = 1'b0;
        controller_address_strobe_n = 1'b0;
        global_write_n = 1'b0;
        drive_en = 1'b1;
        drive_data = 32'h0badf00d;
        tick();
        idle();
        {global_write_n, byte_write_function_en_n} = 2'b10;
        sel_n = 4'he;
        drive_en = 1'b1;
        drive_data = 32'hcafe0001;
        tick();
        settle();
        rd(17'h00010, 32'h12345601);
    endtask

    task automatic t_stream;
        int i;
        for (i = 0; i < 20; i++)
        begin
            wr(17'h00020 + i[16:0], 2'b01, 4'hf, 32'ha0 + i);
            chk(32'h1, {31'h0, write_buffer_ready});
        end
        settle();
    endtask

    task automatic t_burst(input logic lin);
        int         k;
        logic [1:0] st [6];
        logic [1:0] lo;
        st = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0};
        burst_order_linear = lin;
        repeat (2) tick();
        addr = 17'h00021;
        for (k = 0; k < 8; k++)
        begin
            if (k >= 2)
            begin
                lo = lin ? 2'h1 + st[k-2] : 2'h1 ^ st[k-2];
                chk(32'ha0 + {30'h0, lo}, dout);
            end
            controller_address_strobe_n = (k != 0);
            burst_advance = (k > 0 && k < 6 && k != 2);
            tick();
        end
    endtask

    task automatic t_select;
        output_drive_en_n = 1'b1;
        controller_address_strobe_n = 1'b0;
        addr = 17'h00010;
        tick();
        idle();
        tick();
        chk(32'h0, {31'h0, data_lanes_oe});
        output_drive_en_n = 1'b0;
        #1;
        chk(32'h1, {31'h0, data_lanes_oe});
        chk(32'h12345601, dout);
        chip_select_first_n = 1'b1;
        processor_address_strobe_n = 1'b0;
        tick();
        chip_select_first_n = 1'b0;
        idle();
        tick();
        chk(32'h1, {31'h0, data_lanes_oe});
        chip_select_second = 1'b0;
        controller_address_strobe_n = 1'b0;
        tick();
        chip_select_second = 1'b1;
        idle();
        tick();
        chk(32'h0, {31'h0, data_lanes_oe});
        chip_select_first_n = 1'b1;
        processor_address_strobe_n = 1'b0;
        tick();
        chip_select_first_n = 1'b0;
        idle();
        tick();
        chk(32'h0, {31'h0, data_lanes_oe});
    endtask

    task automatic t_sleep;
        sleep_request = 1'b1;
        wait_sleep(1'b1);
        repeat (3) tick();
        sleep_request = 1'b0;
        wait_sleep(1'b0);
        repeat (4) tick();
        rd(17'h1ffff, 32'h55aa55aa);
    endtask

    initial
    begin
        repeat (4) tick();
        srst = 1'b0;
        repeat (2) tick();
        t_writes();
        t_proc_write();
        t_stream();
        t_burst(1'b1);
        t_burst(1'b0);
        t_select();
        t_sleep();
        results();
    end
endmodule
`default_nettype wire
